// ---- shared/lpg_pkg.sv ----
// Purpose: Constants and types shared by the LED PWM group dimming block
// Assumes: pclk at 100 MHz
// Notes:   Offsets are byte addresses on a 32-bit APB bus
`default_nettype none
package lpg_pkg;
    localparam int          NUM_LEDS       = 8;     // Output channels
    localparam int          CLK_PERIOD_NS  = 10;    // pclk period
    // Individual brightness step, least time, rounds up
    localparam int          IND_STEP_NS    = 40;
    localparam int          IND_STEP_CYC   =
        (IND_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Group dimming step, 20.48 us
    localparam int          GRP_STEP_PS    = 20480000;
    localparam int          GRP_STEP_CYC   = GRP_STEP_PS / 10000;
    // Blink sub-step: 256 of them per fastest blink period (24 Hz)
    localparam int          BLINK_SUB_NS   = 163840;
    localparam int          BLINK_SUB_CYC  = BLINK_SUB_NS / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0]  DUTY_BASE      = 8'h00; // 8 words, 00..1C
    localparam logic [7:0]  GRP_DUTY_OFS   = 8'h20;
    localparam logic [7:0]  GRP_FREQ_OFS   = 8'h24;
    localparam logic [7:0]  MODE_OFS       = 8'h28;
    localparam logic [7:0]  OUT_STATE_OFS  = 8'h2C;
    localparam logic [7:0]  STATUS_OFS     = 8'h30;
    // Field positions
    localparam int          MODE_BLINK_BIT = 0;
    localparam int          STAT_PAD_LSB   = 0;     // Pin read-back
    localparam int          STAT_GATE_BIT  = 8;     // Group gate level
    // Reset values
    localparam logic [7:0]  DUTY_RST       = 8'h00;
    localparam logic [7:0]  GRP_DUTY_RST   = 8'hFF; // Full brightness
    localparam logic [7:0]  GRP_FREQ_RST   = 8'h00;
    localparam logic [15:0] OUT_STATE_RST  = 16'h0000;
    // Output state field encodings
    typedef enum logic [1:0] {
        LPG_OFF     = 2'b00,
        LPG_FULL_ON = 2'b01,
        LPG_IND     = 2'b10,
        LPG_IND_GRP = 2'b11
    } lpg_out_state_t;
    // Group signal configuration travels together
    typedef struct packed {
        logic       blink;  // 1 = blinking, 0 = dimming
        logic [7:0] duty;   // Group duty value
        logic [7:0] freq;   // Blink period value
    } lpg_grp_cfg_t;
endpackage
`default_nettype wire

// ---- rtl/lpg_duty_bank.sv ----
// Purpose: Storage of the per-LED duty values
// Assumes: One write port, one registered read port
// Notes:   All values are also offered in parallel for the comparators
`timescale 1ns/100ps
`default_nettype none
module lpg_duty_bank (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_en,
    input  wire logic [2:0]  rd_idx,
    output logic      [7:0]  rd_data,
    output logic      [63:0] all_duty
);
    logic [7:0] mem [lpg_pkg::NUM_LEDS];  // Duty words

    // Write port, one word per access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < lpg_pkg::NUM_LEDS; i++)
                mem[i] <= lpg_pkg::DUTY_RST;
        end
        else if (wr_en)
            mem[wr_idx] <= wr_data;
    end

    // Read data leaves through a register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_data <= 8'h00;
        else if (rd_en)
            rd_data <= mem[rd_idx];
    end

    // Flat view for the pulse comparators
    genvar g;
    generate
        for (g = 0; g < lpg_pkg::NUM_LEDS; g++)
        begin : g_flat
            assign all_duty[g*8 +: 8] = mem[g];
        end
    endgenerate
endmodule // lpg_duty_bank
`default_nettype wire

// ---- rtl/lpg_top.sv ----
// Purpose: LED brightness PWM with superimposed group dimming or blinking
// Assumes: pclk 100 MHz, APB slave with zero wait states
// Notes:   LED pins are open drain, sinking current when lit
// Overview of operation
// RULE_01 - each output: own 8-bit duty fixed PWM
// RULE_02 - one group signal gates group-enabled outputs
// RULE_03 - dimming: fixed 190 Hz, 8-bit duty
// RULE_04 - blinking: 8-bit period, 24 Hz to 10.73 s
// RULE_05 - pulse width is duty times 40 ns
// RULE_06 - group dimming advances in 20.48 us steps
// RULE_07 - group duty 1 passes two pulses
// RULE_08 - group duty 4 passes eight pulses
// RULE_09 - state field: off, on, PWM, PWM+group
// RULE_10 - one bit selects dimming or blinking
`timescale 1ns/100ps
`default_nettype none
module lpg_top #(
    parameter int BLINK_SUB_CYC = lpg_pkg::BLINK_SUB_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  led_output_channel_i,
    output logic      [7:0]  led_output_channel_o,
    output logic      [7:0]  led_output_channel_oe_n
);
    localparam int N = lpg_pkg::NUM_LEDS;

    // Decode helpers used by several processes
    function automatic logic is_duty(input logic [7:0] a);
        return a[7:5] == lpg_pkg::DUTY_BASE[7:5] && a[1:0] == 2'b00;
    endfunction
    function automatic logic is_mapped(input logic [7:0] a);
        return is_duty(a) || a == lpg_pkg::GRP_DUTY_OFS ||
               a == lpg_pkg::GRP_FREQ_OFS || a == lpg_pkg::MODE_OFS ||
               a == lpg_pkg::OUT_STATE_OFS || a == lpg_pkg::STATUS_OFS;
    endfunction

    logic                 setup;        // APB setup cycle
    logic                 wr_acc;       // Write takes effect now
    lpg_pkg::lpg_grp_cfg_t grp_cfg;     // Group signal settings
    logic [15:0]          out_state;    // Two bits per LED
    logic [63:0]          all_duty;     // Duty values, flat
    logic [7:0]           bank_rd;      // Registered duty read
    logic                 rd_duty;      // Last setup read a duty word
    logic [31:0]          reg_rd;       // Registered other read
    logic [7:0]           pad_s1;       // Pin sync, first stage
    logic [7:0]           pad_s2;       // Pin sync, second stage
    logic [1:0]           pre;          // 40 ns step prescaler
    logic [7:0]           ind_cnt;      // Individual PWM position
    logic                 ind_par;      // Odd/even individual period
    logic [7:0]           grp_phase;    // Group signal position
    logic [$clog2(BLINK_SUB_CYC)-1:0] blink_sub; // Blink sub-step
    logic [7:0]           blink_div;    // Blink period divider
    logic                 dim_tick;     // One 20.48 us step done
    logic                 blink_tick;   // One blink step done
    logic                 grp_tick;     // Group phase advances
    logic                 gate;         // Group signal level
    logic [N-1:0]         pwm_on;       // Individual pulse levels
    logic [N-1:0]         next_lit;     // Pin drive wanted

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;

    // Error answer for unmapped addresses during the access phase
    assign pslverr = psel && penable && !is_mapped(paddr);

    // Duty words live in their own storage
    lpg_duty_bank u_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_en    (wr_acc && is_duty(paddr)),
        .wr_idx   (paddr[4:2]),
        .wr_data  (pwdata[7:0]),
        .rd_en    (setup && !pwrite),
        .rd_idx   (paddr[4:2]),
        .rd_data  (bank_rd),
        .all_duty (all_duty)
    );

    // Control registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_cfg.blink <= 1'b0;
            grp_cfg.duty  <= lpg_pkg::GRP_DUTY_RST;
            grp_cfg.freq  <= lpg_pkg::GRP_FREQ_RST;
            out_state     <= lpg_pkg::OUT_STATE_RST; // RULE_09
        end
        else if (wr_acc)
        begin
            case (paddr)
                lpg_pkg::GRP_DUTY_OFS:  grp_cfg.duty  <= pwdata[7:0];
                lpg_pkg::GRP_FREQ_OFS:  grp_cfg.freq  <= pwdata[7:0];
                // One bit for all outputs at once
                lpg_pkg::MODE_OFS:
                    // RULE_10
                    grp_cfg.blink <= pwdata[lpg_pkg::MODE_BLINK_BIT];
                lpg_pkg::OUT_STATE_OFS: out_state <= pwdata[15:0];
                default:                ;
            endcase
        end
    end

    // Non-duty read data, captured at setup so the access phase is ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reg_rd  <= 32'h0000_0000;
            rd_duty <= 1'b0;
        end
        else if (setup && !pwrite)
        begin
            rd_duty <= is_duty(paddr);
            case (paddr)
                lpg_pkg::GRP_DUTY_OFS:  reg_rd <= {24'h0, grp_cfg.duty};
                lpg_pkg::GRP_FREQ_OFS:  reg_rd <= {24'h0, grp_cfg.freq};
                lpg_pkg::MODE_OFS:      reg_rd <= {31'h0, grp_cfg.blink};
                lpg_pkg::OUT_STATE_OFS: reg_rd <= {16'h0, out_state};
                // Live state: pin levels and group gate
                lpg_pkg::STATUS_OFS:
                    reg_rd <= {23'h0, gate, pad_s2};
                default:                reg_rd <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = rd_duty ? {24'h0, bank_rd} : reg_rd;

    // Pin read-back crosses in through two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_s1 <= 8'hFF;
            pad_s2 <= 8'hFF;
        end
        else
        begin
            pad_s1 <= led_output_channel_i;
            pad_s2 <= pad_s1;
        end
    end

    // Individual timebase: 40 ns steps, 256 per period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre     <= 2'd0;
            ind_cnt <= 8'h00;
            ind_par <= 1'b0;
        end
        else
        begin
            pre <= (pre == 2'(lpg_pkg::IND_STEP_CYC - 1)) ? 2'd0
                                                          : pre + 2'd1; // RULE_05
            if (pre == 2'(lpg_pkg::IND_STEP_CYC - 1))
            begin
                ind_cnt <= ind_cnt + 8'h01; // RULE_01
                if (ind_cnt == 8'hFF)
                    ind_par <= !ind_par;
            end
        end
    end

    // Two individual periods make one 20.48 us group step, so every dimming
    // group step starts on a fresh individual pulse
    assign dim_tick = pre == 2'(lpg_pkg::IND_STEP_CYC - 1) &&
                      ind_cnt == 8'hFF && ind_par; // RULE_06

    // Blink timebase: sub-steps divided by the programmed period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blink_sub <= '0;
            blink_div <= 8'h00;
        end
        else if (!grp_cfg.blink)
        begin
            // Held idle so a switch to blinking starts cleanly
            blink_sub <= '0;
            blink_div <= 8'h00;
        end
        else if (blink_sub == ($bits(blink_sub))'(BLINK_SUB_CYC - 1))
        begin
            blink_sub <= '0;
            // RULE_04
            blink_div <= (blink_div >= grp_cfg.freq) ? 8'h00
                                                     : blink_div + 8'h01;
        end
        else
            blink_sub <= blink_sub + 1'b1;
    end
    assign blink_tick = blink_sub == ($bits(blink_sub))'(BLINK_SUB_CYC - 1) &&
                        blink_div >= grp_cfg.freq;
    assign grp_tick   = grp_cfg.blink ? blink_tick : dim_tick; // RULE_10

    // Group phase: 256 steps per group period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            grp_phase <= 8'h00;
        else if (grp_tick)
            grp_phase <= grp_phase + 8'h01; // RULE_03
    end
    // Duty M keeps the gate open for M steps
    assign gate = grp_phase < grp_cfg.duty; // RULE_07 RULE_08

    // Per-output pulse and state select
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_led
            assign pwm_on[g] = ind_cnt < all_duty[g*8 +: 8]; // RULE_01
            always_comb
            begin
                case (lpg_pkg::lpg_out_state_t'(out_state[2*g +: 2]))
                    lpg_pkg::LPG_OFF:     next_lit[g] = 1'b0; // RULE_09
                    lpg_pkg::LPG_FULL_ON: next_lit[g] = 1'b1;
                    lpg_pkg::LPG_IND:     next_lit[g] = pwm_on[g];
                    lpg_pkg::LPG_IND_GRP:
                        next_lit[g] = pwm_on[g] && gate; // RULE_02
                    default:              next_lit[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Open drain: pull low when lit, release otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            led_output_channel_oe_n <= 8'hFF;
        else
            led_output_channel_oe_n <= ~next_lit;
    end
    assign led_output_channel_o = 8'h00;

    // Checks
    step_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        $changed(ind_cnt) |-> $past(pre) == 2'd3)
        else $error("individual step not 40 ns");
    min_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        // A duty write mid-step would cut the first pulse short
        $rose(pwm_on[0]) && all_duty[7:0] == 8'h01 &&
        $stable(all_duty[7:0]) |->
            pwm_on[0] [*4] ##1 !pwm_on[0])
        else $error("one-count pulse not 40 ns");
    state_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        out_state[1:0] == 2'b00 |=> led_output_channel_oe_n[0])
        else $error("off output driven");
    state_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        out_state[1:0] == 2'b01 |=> !led_output_channel_oe_n[0])
        else $error("full-on output released");
    ind_only_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        out_state[1:0] == 2'b10 |=>
            led_output_channel_oe_n[0] == !$past(pwm_on[0]))
        else $error("individual pulse not passed");
    grp_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        out_state[1:0] == 2'b11 && !gate |=> led_output_channel_oe_n[0])
        else $error("group gate ignored");
    dim_align_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        dim_tick && !grp_cfg.blink |=> (ind_cnt == 8'h00) [*4])
        else $error("group step not aligned to pulse");
    grp_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        grp_cfg.duty == 8'h00 |-> !gate)
        else $error("gate open at zero duty");
    bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr == 8'h34 |-> pslverr)
        else $error("unmapped address accepted");
endmodule // lpg_top
`default_nettype wire

// ---- dv/lpg_led_model.sv ----
// Purpose: Open-drain LED loads with pull-up and pulse meters
// Assumes: Pins sampled on the pclk rising edge
// Notes:   A released pin floats to the pull-up level
`timescale 1ns/100ps
`default_nettype none
module lpg_led_model (
    input  wire logic             pclk,
    input  wire logic             clr,
    input  wire logic [7:0]       drv_o,
    input  wire logic [7:0]       drv_oe_n,
    output logic      [7:0]       pin,
    output logic      [7:0][15:0] falls,
    output logic      [7:0][11:0] width,
    output logic      [7:0][11:0] period
);
    logic [7:0]       prev;    // Pin level one edge ago
    logic [7:0][11:0] run_low; // Low samples so far
    logic [7:0][11:0] run_all; // Samples since last fall
    // Pull-up wins whenever the driver lets go
    assign pin = drv_oe_n | drv_o;
    // Meter every channel; counts are only trusted after a clear
    always_ff @(posedge pclk)
    begin
        prev <= pin;
        for (int i = 0; i < 8; i++)
        begin
            run_low[i] <= pin[i] ? 12'h000 : run_low[i] + 12'h001;
            run_all[i] <= (prev[i] & ~pin[i]) ? 12'h001 : run_all[i] + 12'h001;
            if (~prev[i] & pin[i]) width[i] <= run_low[i];
            if (prev[i] & ~pin[i]) period[i] <= run_all[i];
            if (clr) falls[i] <= 16'h0000;
            else if (prev[i] & ~pin[i]) falls[i] <= falls[i] + 16'h0001;
        end
    end
endmodule // lpg_led_model
`default_nettype wire

// ---- dv/lpg_top_tb.sv ----
// Purpose: Self-checking bench for the LED PWM group block
// Assumes: Zero-wait APB slave, short blink sub-step
// Notes:   Counters restart at reset, so group tests reset first
`timescale 1ns/100ps
`default_nettype none
module lpg_top_tb;
    localparam int SUB   = 4;     // Short blink sub-step
    localparam int LIMIT = 90000; // Cycle ceiling
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic             clr = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h00000000;
    logic [31:0]      prdata, rd;
    logic             pready, pslverr, err;
    logic [7:0]       pin_lvl, o_lvl, oe_n;
    logic [7:0][15:0] falls;
    logic [7:0][11:0] width, period;
    int               errors = 0;
    int               samples_checked = 0;
    int               cyc = 0;
    int               d;
    int               mv [3] = '{0, 1, 4}; // Group duty values tried
    int               model [int]; // Expected register contents
    int               mask [int];  // Implemented bits per register
    // Free-running clock
    always #5 pclk = ~pclk;
    lpg_top #(.BLINK_SUB_CYC(SUB)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .led_output_channel_i(pin_lvl),
        .led_output_channel_o(o_lvl), .led_output_channel_oe_n(oe_n));
    lpg_led_model leds (.pclk(pclk), .clr(clr), .drv_o(o_lvl),
        .drv_oe_n(oe_n), .pin(pin_lvl), .falls(falls), .width(width),
        .period(period));
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Case-equal compare so unknowns never match
    task check(input string what, input logic [31:0] exp,
               input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] dat);
        xfer(a, 1'b1, dat);
        if (mask.exists(a)) model[a] = dat & mask[a];
    endtask
    task rd_chk(input logic [7:0] a);
        xfer(a, 1'b0, 32'h00000000);
        check("prdata", mask.exists(a) ? model[a] : 0, rd);
        check("pslverr", mask.exists(a) ? 0 : 1, {31'h0, err});
    endtask
    // Reset also restarts the expected register image
    task do_reset;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (mask[k]) model[k] = 0;
        model[lpg_pkg::GRP_DUTY_OFS] = 32'hFF;
    endtask
    task pulse_clr;
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            errors++;
            complete_run;
        end
    end
    // Main sequence
    initial
    begin
        void'($urandom(25));
        for (int i = 0; i < 8; i++) mask[lpg_pkg::DUTY_BASE + 4 * i] = 32'hFF;
        mask[lpg_pkg::GRP_DUTY_OFS] = 32'hFF;
        mask[lpg_pkg::GRP_FREQ_OFS] = 32'hFF;
        mask[lpg_pkg::MODE_OFS] = 32'h1;
        mask[lpg_pkg::OUT_STATE_OFS] = 32'hFFFF;
        do_reset;
        check("oe_n", 32'hFF, {24'h0, oe_n});
        foreach (mask[k]) rd_chk(8'(k));
        foreach (mask[k]) wr(8'(k), $urandom());
        wr(8'h40, $urandom());
        foreach (mask[k]) rd_chk(8'(k));
        rd_chk(8'h40);
        // Off, full on and individual PWM side by side
        do_reset;
        pulse_clr;
        wr(lpg_pkg::OUT_STATE_OFS, 32'h1);
        repeat (4) @(posedge pclk);
        xfer(lpg_pkg::STATUS_OFS, 1'b0, 32'h0);
        check("status", 32'h1FE, rd);
        d = $urandom_range(200, 2);
        wr(lpg_pkg::DUTY_BASE + 4, 32'h1);
        wr(lpg_pkg::DUTY_BASE + 12, d);
        wr(lpg_pkg::OUT_STATE_OFS, 32'h289);
        repeat (3000) @(posedge pclk);
        check("width1", lpg_pkg::IND_STEP_CYC, width[1]);
        check("width3", d * lpg_pkg::IND_STEP_CYC, width[3]);
        check("period3", 256 * lpg_pkg::IND_STEP_CYC, period[3]);
        check("falls4", 0, falls[4]);
        check("falls0", 1, falls[0]);
        check("drive_o", 0, o_lvl);
        // Group dimming: pulses admitted in the first group period
        foreach (mv[j])
        begin
            do_reset;
            pulse_clr;
            wr(lpg_pkg::DUTY_BASE + 8, 32'hFF);
            wr(lpg_pkg::GRP_DUTY_OFS, mv[j]);
            wr(lpg_pkg::OUT_STATE_OFS, 32'h30);
            repeat (12000) @(posedge pclk);
            d = mv[j] * lpg_pkg::GRP_STEP_CYC / 1024;
            check("falls2", d, falls[2]);
        end
        // Blinking at half duty, then dimming with the group duty at FF
        do_reset;
        wr(lpg_pkg::DUTY_BASE + 20, 32'h1);
        wr(lpg_pkg::GRP_DUTY_OFS, 32'h80);
        wr(lpg_pkg::GRP_FREQ_OFS, 32'h1);
        wr(lpg_pkg::MODE_OFS, 32'h1);
        wr(lpg_pkg::OUT_STATE_OFS, 32'hC00);
        repeat (1000) @(posedge pclk);
        pulse_clr;
        repeat (8 * 256 * 2 * SUB) @(posedge pclk);
        check("blink", 8 * 2 * SUB * 128 / 1024, falls[5]);
        // Group phase is left near 128 by blinking; open the gate wide
        // so the whole dimming window passes every individual pulse
        wr(lpg_pkg::GRP_DUTY_OFS, 32'hFF);
        wr(lpg_pkg::MODE_OFS, 32'h0);
        pulse_clr;
        repeat (16384) @(posedge pclk);
        check("dim", 16, falls[5]);
        complete_run;
    end
endmodule // lpg_top_tb
`default_nettype wire
